// ===== hw/tap_boundary_scan.sv
/*
 * Boundary-scan test access port with configuration-control
 * instructions. The controller, instruction and data registers run on
 * the test clock; pin multiplexers and configuration outputs run on
 * the system clock. Assumes tck_in keeps running while srst_in is high
 * so the controller sees the reset, and for at least one cycle after
 * each update so that new settings reach the system clock.
 */
// Operation
// - user clock instruction selects user clock pin
// - oscillator instruction returns clock to oscillator
// - idle instruction stops active configuration controllers
// - engage instruction restarts active configuration controllers
// - boot pointer instruction links 22-bit address register
// - shifted boot address sets factory image start
// - sixteen-state controller advances on test clock
// - reset state: normal pins, identification instruction
// - controller starts in reset state
// - five high mode-select cycles reach reset
// - reset state holds while mode-select high
// - data-out driven only in shift states
// - instruction shift emits 1010101010 first
// - instruction bits sampled on rising edges
// - instruction shift holds while mode-select low
// - sample capture keeps pins on functional data
// - data shift chains capture registers
// - update copies capture into update registers
// - two high cycles go shift to update
// - external test drives pins from update registers
// - external test captures observed pin values
// - all-ones code selects bypass bit

`timescale 1ns/1ps
`default_nettype none

module tap_boundary_scan
   import tap_pkg::*;
(
   // system clock and reset
   input  wire logic                 clk_sys_in,
   input  wire logic                 srst_in,
   // test link
   input  wire logic                 tck_in,
   input  wire logic                 tms_in,
   input  wire logic                 tdi_in,
   output var  logic                 tdo_out,
   output var  logic                 tdo_en_n_out,
   // device pins and core side
   input  wire logic [`BSR_PINS-1:0] pin_in,
   input  wire logic [`BSR_PINS-1:0] core_out_in,
   input  wire logic [`BSR_PINS-1:0] core_oe_in,
   output var  logic [`BSR_PINS-1:0] pin_out_out,
   output var  logic [`BSR_PINS-1:0] pin_oe_out,
   // configuration control
   output var  logic                 clk_src_user_out,
   output var  logic                 active_idle_out,
   output var  logic [`BOOT_W-1:0]   boot_addr_out
);

   localparam int CHAIN = `BSR_PINS * `CELL_BITS;

   // ============================================================
   // decode helper shared by the configuration instructions
   // true on the update edge that installs the code; acting on the
   // shifted word lets the effect land together with the instruction
   function automatic logic code_loaded(input tap_state_t       st,
                                        input logic [`IR_W-1:0] shifted,
                                        input logic [`IR_W-1:0] code);
      return (st == st_upd_ir) && (shifted == code);
   endfunction : code_loaded

   // ============================================================
   // test clock domain: reset and pin synchronisers
   logic                 rst_meta;
   logic                 rst_tck;
   logic [CHAIN-1:0]     obs_meta;
   logic [CHAIN-1:0]     obs;

   // both stages of each synchroniser are read only in order
   always_ff @(posedge tck_in) begin
      rst_meta <= srst_in;
      rst_tck  <= rst_meta;
   end

   // observed pin input, driven output and enable per cell
   always_ff @(posedge tck_in) begin
      obs_meta <= {pin_in, pin_out_out, pin_oe_out};
      obs      <= obs_meta;
   end

   // ============================================================
   // controller
   tap_state_t state;
   tap_state_t next_state;

   // next state depends on mode-select alone
   always_comb begin
      unique case (state)
         st_reset:    next_state = tms_in ? st_reset    : st_idle;
         st_idle:     next_state = tms_in ? st_sel_dr   : st_idle;
         st_sel_dr:   next_state = tms_in ? st_sel_ir   : st_cap_dr;
         st_cap_dr:   next_state = tms_in ? st_exit1_dr : st_shift_dr;
         st_shift_dr: next_state = tms_in ? st_exit1_dr : st_shift_dr;
         st_exit1_dr: next_state = tms_in ? st_upd_dr   : st_pause_dr;
         st_pause_dr: next_state = tms_in ? st_exit2_dr : st_pause_dr;
         st_exit2_dr: next_state = tms_in ? st_upd_dr   : st_shift_dr;
         st_upd_dr:   next_state = tms_in ? st_sel_dr   : st_idle;
         st_sel_ir:   next_state = tms_in ? st_reset    : st_cap_ir;
         st_cap_ir:   next_state = tms_in ? st_exit1_ir : st_shift_ir;
         st_shift_ir: next_state = tms_in ? st_exit1_ir : st_shift_ir;
         st_exit1_ir: next_state = tms_in ? st_upd_ir   : st_pause_ir;
         st_pause_ir: next_state = tms_in ? st_exit2_ir : st_pause_ir;
         st_exit2_ir: next_state = tms_in ? st_upd_ir   : st_shift_ir;
         st_upd_ir:   next_state = tms_in ? st_sel_dr   : st_idle;
      endcase
   end

   // every tms-high path reaches reset within five edges
   always_ff @(posedge tck_in) begin
      if (rst_tck) begin
         state <= st_reset;
      end else begin
         state <= next_state;
      end
   end

   // ============================================================
   // instruction register
   logic [`IR_W-1:0] ir_sr;
   logic [`IR_W-1:0] ir;

   // capture pattern shifts out lsb first as 1010101010
   always_ff @(posedge tck_in) begin
      if (state == st_cap_ir) begin
         ir_sr <= `IR_CAPTURE;
      end else if (state == st_shift_ir) begin
         ir_sr <= {tdi_in, ir_sr[`IR_W-1:1]};
      end
   end

   // active instruction, back to identification whenever reset is seen
   always_ff @(posedge tck_in) begin
      if (rst_tck || state == st_reset) begin
         ir <= `INS_IDCODE;
      end else if (state == st_upd_ir) begin
         ir <= ir_sr;
      end
   end

   // ============================================================
   // configuration instructions, acted on when the code is loaded
   logic clk_user;
   logic active_idle;

   // clock source survives the reset state; srst or the oscillator code returns it
   always_ff @(posedge tck_in) begin
      if (rst_tck) begin
         clk_user <= 1'b0;
      end else if (code_loaded(state, ir_sr, `INS_USER_CLK)) begin
         clk_user <= 1'b1;
      end else if (code_loaded(state, ir_sr, `INS_OSC_CLK)) begin
         clk_user <= 1'b0;
      end
   end

   // idle request for the active configuration controllers
   always_ff @(posedge tck_in) begin
      if (rst_tck) begin
         active_idle <= 1'b0;
      end else if (code_loaded(state, ir_sr, `INS_IDLE)) begin
         active_idle <= 1'b1;
      end else if (code_loaded(state, ir_sr, `INS_ENGAGE)) begin
         active_idle <= 1'b0;
      end
   end

   // ============================================================
   // data registers
   logic                ins_bsr;
   logic                ins_boot;
   logic                ins_id;
   logic [CHAIN-1:0]    bsr;
   logic [CHAIN-1:0]    upd;
   logic [`BOOT_W-1:0]  boot_sr;
   logic [`BOOT_W-1:0]  boot_addr;
   logic [`ID_W-1:0]    id_sr;
   logic                byp;

   assign ins_bsr  = (ir == `INS_SAMPLE) || (ir == `INS_EXTEST);
   assign ins_boot = (ir == `INS_BOOT_PTR);
   assign ins_id   = (ir == `INS_IDCODE);

   // sample and extest both capture pin input, driven output and enable
   always_ff @(posedge tck_in) begin
      if (ins_bsr && state == st_cap_dr) begin
         bsr <= obs;
      end else if (ins_bsr && state == st_shift_dr) begin
         bsr <= {tdi_in, bsr[CHAIN-1:1]};
      end
   end

   // update cells, only touched by the boundary instructions
   always_ff @(posedge tck_in) begin
      if (rst_tck) begin
         upd <= '0;
      end else if (ins_bsr && state == st_upd_dr) begin
         upd <= bsr;
      end
   end

   // boot shifter captures the live address so it can be read back
   always_ff @(posedge tck_in) begin
      if (ins_boot && state == st_cap_dr) begin
         boot_sr <= boot_addr;
      end else if (ins_boot && state == st_shift_dr) begin
         boot_sr <= {tdi_in, boot_sr[`BOOT_W-1:1]};
      end
   end

   // boot address changes only on a completed update
   always_ff @(posedge tck_in) begin
      if (rst_tck) begin
         boot_addr <= `BOOT_RST;
      end else if (ins_boot && state == st_upd_dr) begin
         boot_addr <= boot_sr;
      end
   end

   // identification value is arbitrary
   always_ff @(posedge tck_in) begin
      if (ins_id && state == st_cap_dr) begin
         id_sr <= `ID_VALUE;
      end else if (ins_id && state == st_shift_dr) begin
         id_sr <= {tdi_in, id_sr[`ID_W-1:1]};
      end
   end

   // bypass bit serves all-ones and every unknown code
   always_ff @(posedge tck_in) begin
      if (state == st_cap_dr) begin
         byp <= 1'b0;
      end else if (state == st_shift_dr) begin
         byp <= tdi_in;
      end
   end

   // ============================================================
   // data-out on falling edge, so the far end samples a settled bit
   logic serial_bit;

   // serial source follows the active instruction
   always_comb begin
      if (state == st_shift_ir) begin
         serial_bit = ir_sr[0];
      end else if (ins_bsr) begin
         serial_bit = bsr[0];
      end else if (ins_boot) begin
         serial_bit = boot_sr[0];
      end else if (ins_id) begin
         serial_bit = id_sr[0];
      end else begin
         serial_bit = byp;
      end
   end

   // enable low only while a shift state is active
   always_ff @(negedge tck_in) begin
      if (rst_tck) begin
         tdo_out      <= 1'b0;
         tdo_en_n_out <= 1'b1;
      end else begin
         tdo_out      <= serial_bit;
         tdo_en_n_out <= !(state == st_shift_ir || state == st_shift_dr);
      end
   end

   // ============================================================
   // crossing: request/acknowledge toggles, word held while pending
   cfg_t live;
   cfg_t sent;
   logic req;
   logic ack;
   logic ack_meta;
   logic ack_tck;

   always_comb begin
      live             = '0;
      live.clk_user    = clk_user;
      live.active_idle = active_idle;
      live.boot_addr   = boot_addr;
      live.extest      = (ir == `INS_EXTEST);
      for (int i = 0; i < `BSR_PINS; i++) begin
         live.upd_out[i] = upd[`BSR_PINS + i];
         live.upd_oe[i]  = upd[i];
      end
   end

   // acknowledge back into the test clock, two stages
   always_ff @(posedge tck_in) begin
      ack_meta <= ack;
      ack_tck  <= ack_meta;
   end

   // a new word is only offered once the last one is acknowledged
   always_ff @(posedge tck_in) begin
      if (rst_tck) begin
         req  <= 1'b0;
         sent <= '0;
      end else if (req == ack_tck && live != sent) begin
         req  <= ~req;
         sent <= live;
      end
   end

   // ============================================================
   // system clock domain
   logic req_meta;
   logic req_sys;
   cfg_t cfg;

   // request into the system clock, two stages
   always_ff @(posedge clk_sys_in) begin
      req_meta <= req;
      req_sys  <= req_meta;
   end

   // the word is stable while the request is pending, so take it whole
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         ack <= 1'b0;
         cfg <= '0;
      end else if (req_sys != ack) begin
         ack <= ~ack;
         cfg <= sent;
      end
   end

   // pins follow the core unless external test owns them
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         pin_out_out <= '0;
         pin_oe_out  <= '0;
      end else if (cfg.extest) begin
         pin_out_out <= cfg.upd_out;
         pin_oe_out  <= cfg.upd_oe;
      end else begin
         pin_out_out <= core_out_in;
         pin_oe_out  <= core_oe_in;
      end
   end

   // configuration clock source select
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         clk_src_user_out <= 1'b0;
      end else begin
         clk_src_user_out <= cfg.clk_user;
      end
   end

   // active configuration controllers held idle while set
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         active_idle_out <= 1'b0;
      end else begin
         active_idle_out <= cfg.active_idle;
      end
   end

   // factory image start handed to the flash controller
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         boot_addr_out <= `BOOT_RST;
      end else begin
         boot_addr_out <= cfg.boot_addr;
      end
   end

endmodule : tap_boundary_scan

`default_nettype wire

// ===== hw/tap_params.svh
/*
 * Holds the constants of the boundary-scan access port: instruction
 * codes, register widths, capture patterns and reset values.
 * Assumes it is included by the package file, the checker and the bench.
 */
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

// ============================================================
// widths
`define IR_W          10
`define BOOT_W        22
`define ID_W          32
`define BSR_PINS      4
`define CELL_BITS     3

// ============================================================
// instruction codes
`define INS_SAMPLE    10'h005
`define INS_EXTEST    10'h00F
`define INS_BYPASS    10'h3FF
`define INS_IDCODE    10'h006
`define INS_USER_CLK  10'h1EE
`define INS_OSC_CLK   10'h2EE
`define INS_IDLE      10'h2D0
`define INS_ENGAGE    10'h2B0
`define INS_BOOT_PTR  10'h270

// ============================================================
// capture values and reset values
`define IR_CAPTURE    10'h155
`define ID_VALUE      32'h0000_0001
`define BOOT_RST      22'h00_0000

`endif

// ===== hw/tap_pkg.sv
/*
 * Types of the boundary-scan access port: controller states and the
 * word that carries settings from the test clock to the system clock.
 * Assumes tap_params.svh sits beside it.
 */
`include "tap_params.svh"

package tap_pkg;

   // ============================================================
   // controller states, gray steps in declaration order
   typedef enum logic [3:0] {
      st_reset      = 4'h0,
      st_idle       = 4'h1,
      st_sel_dr     = 4'h3,
      st_cap_dr     = 4'h2,
      st_shift_dr   = 4'h6,
      st_exit1_dr   = 4'h7,
      st_pause_dr   = 4'h5,
      st_exit2_dr   = 4'h4,
      st_upd_dr     = 4'hC,
      st_sel_ir     = 4'hD,
      st_cap_ir     = 4'hF,
      st_shift_ir   = 4'hE,
      st_exit1_ir   = 4'hA,
      st_pause_ir   = 4'hB,
      st_exit2_ir   = 4'h9,
      st_upd_ir     = 4'h8
   } tap_state_t;

   // ============================================================
   // settings handed to the system clock domain
   typedef struct packed {
      logic                            clk_user;
      logic                            active_idle;
      logic [`BOOT_W-1:0]              boot_addr;
      logic                            extest;
      logic [`BSR_PINS-1:0]            upd_out;
      logic [`BSR_PINS-1:0]            upd_oe;
   } cfg_t;

endpackage : tap_pkg

// ===== tb/tap_host.sv
/* Model of the external test controller that walks the scan port.
   Assumes a pull-up on the board holds data-out high when released. */
`timescale 1ns/1ps
`default_nettype none
module tap_host (
   // link to the port
   output var  logic tck_out,
   output var  logic tms_out,
   output var  logic tdi_out,
   input  wire logic tdo_in,
   input  wire logic tdo_en_n_in
);
   logic tdo_wire;
   // released line reads the pull-up level, never the stale bit
   assign tdo_wire = tdo_en_n_in ? 1'b1 : tdo_in;
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end
   // one test clock; lines move while tck is low, tdo read just before the rise
   task automatic step(input logic m, input logic d, output logic q);
      tms_out = m;
      tdi_out = d;
      #62.5;
      q = tdo_wire;
      tck_out = 1'b1;
      #62.5;
      tck_out = 1'b0;
   endtask : step
   // five high steps force reset from anywhere, then park in idle
   task automatic reset5();
      logic q;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask : reset5
   // idle to shift, n bits lsb first, update, idle clocks for the crossing
   task automatic shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      #7.3;
      step(1'b1, 1'b0, q);
      if (ir) step(1'b1, 1'b0, q);
      repeat (2) step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      repeat (2) step(1'b0, 1'b0, q);
   endtask : shift
endmodule : tap_host
`default_nettype wire

// ===== tb/tap_boundary_scan_asserts.sv
/* Checker of the scan port's link and configuration outputs.
   Assumes it is bound to tap_boundary_scan and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
`include "tap_params.svh"
module tap_scan_checker (
   // clocks and reset
   input wire logic               clk_sys_in,
   input wire logic               srst_in,
   input wire logic               tck_in,
   // link
   input wire logic               tms_in,
   input wire logic               tdo_out,
   input wire logic               tdo_en_n_out,
   // configuration
   input wire logic               clk_src_user_out,
   input wire logic               active_idle_out,
   input wire logic [`BOOT_W-1:0] boot_addr_out
);
   // ==========================================================
   // link rules, tck domain
   sequence ir_walk;
      tms_in[*5] ##1 !tms_in ##1 tms_in[*2] ##1 !tms_in[*2];
   endsequence
   a_reset_tdo_off: assert property (@(posedge tck_in) srst_in[*4] |-> tdo_en_n_out)
      else $error("data-out driven during reset");
   a_five_high_reset: assert property (@(posedge tck_in) disable iff (srst_in) tms_in[*5] |=> tdo_en_n_out)
      else $error("five high steps left data-out driven");
   a_ir_entry: assert property (@(posedge tck_in) disable iff (srst_in) ir_walk |=> !tdo_en_n_out && tdo_out)
      else $error("instruction shift entry wrong");
   a_ir_second_bit: assert property (@(posedge tck_in) disable iff (srst_in) ir_walk ##1 !tms_in |=> !tdo_out)
      else $error("second instruction bit not low");
   a_shift_exit_off: assert property (@(posedge tck_in) disable iff (srst_in) !tdo_en_n_out && tms_in |=> tdo_en_n_out)
      else $error("data-out still driven after shift");
   a_shift_hold: assert property (@(posedge tck_in) disable iff (srst_in) !tdo_en_n_out && !tms_in |=> !tdo_en_n_out)
      else $error("shift left with mode-select low");
   // ==========================================================
   // timing and system domain
   a_tdo_fall_only: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      tck_in && $past(tck_in) |-> $stable({tdo_out, tdo_en_n_out})) else $error("data-out moved while tck high");
   a_cfg_reset_clear: assert property (@(posedge clk_sys_in) srst_in |=>
      !clk_src_user_out && !active_idle_out && boot_addr_out == '0) else $error("settings not cleared by reset");
   c_ir_walk: cover property (@(posedge tck_in) ir_walk);
   c_user_clk: cover property (@(posedge clk_sys_in) $rose(clk_src_user_out));
   c_idle: cover property (@(posedge clk_sys_in) $rose(active_idle_out));
endmodule : tap_scan_checker
bind tap_boundary_scan tap_scan_checker chk (.clk_sys_in, .srst_in, .tck_in, .tms_in, .tdo_out, .tdo_en_n_out,
   .clk_src_user_out, .active_idle_out, .boot_addr_out);
`default_nettype wire

// ===== tb/tap_boundary_scan_test.sv
/* Self-checking bench of the scan port, driven by the tap_host model.
   Assumes the design and tap_params.svh are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "tap_params.svh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin error_cnt++; $display("ERROR %s expected %h seen %h", n, e, a); end end
module tap_boundary_scan_test;
   logic                 clk_sys_in = 1'b0;
   logic                 srst_in    = 1'b1;
   logic                 tck, tms, tdi, tdo, tdo_en_n, q;
   logic [`BSR_PINS-1:0] pin_in = 4'h0, core_out = 4'h0, core_oe = 4'h0, pin_out, pin_oe;
   logic                 clk_src_user, active_idle;
   logic [`BOOT_W-1:0]   boot_addr;
   logic [31:0]          dout;
   int                   error_cnt = 0, check_count = 0, cycles = 0;
   always #20 clk_sys_in = ~clk_sys_in;
   tap_boundary_scan uut (
      .clk_sys_in(clk_sys_in), .srst_in(srst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
      .tdo_out(tdo), .tdo_en_n_out(tdo_en_n), .pin_in(pin_in), .core_out_in(core_out),
      .core_oe_in(core_oe), .pin_out_out(pin_out), .pin_oe_out(pin_oe),
      .clk_src_user_out(clk_src_user), .active_idle_out(active_idle), .boot_addr_out(boot_addr));
   tap_host host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo), .tdo_en_n_in(tdo_en_n));
   // hang guard; the run needs well under a tenth of this
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         error_cnt++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   // instruction load, then time for the settings handshake to land
   task automatic load(input logic [9:0] code);
      host.shift(1'b1, 10, {22'h0, code}, dout);
      repeat (12) @(posedge clk_sys_in);
   endtask : load
   task automatic t_reset();
      host.shift(1'b0, 32, 32'h0, dout);
      `CHK("power-up idcode", `ID_VALUE, dout)
      host.reset5();
      host.shift(1'b1, 10, {22'h0, `INS_BYPASS}, dout);
      `CHK("ir capture", {22'h0, `IR_CAPTURE}, dout)
      $display("test reset done");
   endtask : t_reset
   task automatic t_bypass();
      logic [9:0] codes [2] = '{`INS_BYPASS, 10'h123};
      foreach (codes[k]) begin
         load(codes[k]);
         host.shift(1'b0, 8, 32'hA5, dout);
         `CHK("bypass", 32'h4A, dout)
      end
      $display("test bypass done");
   endtask : t_bypass
   task automatic t_config();
      logic [9:0] code [4] = '{`INS_USER_CLK, `INS_IDLE, `INS_OSC_CLK, `INS_ENGAGE};
      logic [1:0] want [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
      foreach (code[k]) begin
         load(code[k]);
         `CHK("clk src and idle", want[k], {clk_src_user, active_idle})
      end
      $display("test config done");
   endtask : t_config
   task automatic t_boot();
      load(`INS_BOOT_PTR);
      host.shift(1'b0, 22, 32'h2A_5C3F, dout);
      repeat (12) @(posedge clk_sys_in);
      `CHK("boot addr", 22'h2A_5C3F, boot_addr)
      `CHK("boot capture", 32'h0, dout)
      host.shift(1'b0, 22, 32'h15_A3C0, dout);
      `CHK("boot chain", 32'h2A_5C3F, dout)
      $display("test boot done");
   endtask : t_boot
   task automatic t_pins();
      @(posedge clk_sys_in);
      pin_in   <= 4'h6;
      core_out <= 4'hA;
      core_oe  <= 4'hF;
      load(`INS_SAMPLE);
      host.shift(1'b0, 12, 32'h053, dout);
      repeat (12) @(posedge clk_sys_in);
      `CHK("sample capture", 32'h6AF, dout)
      `CHK("sample pins", 8'hAF, {pin_out, pin_oe})
      load(`INS_EXTEST);
      `CHK("extest pins", 8'h53, {pin_out, pin_oe})
      host.shift(1'b0, 12, 32'h0, dout);
      `CHK("extest capture", 32'h653, dout)
      host.reset5();
      repeat (12) @(posedge clk_sys_in);
      `CHK("reset pins", 8'hAF, {pin_out, pin_oe})
      $display("test pins done");
   endtask : t_pins
   initial begin
      // tck must run while reset is high so the link side sees it
      repeat (4) host.step(1'b1, 1'b0, q);
      @(posedge clk_sys_in);
      srst_in <= 1'b0;
      repeat (3) host.step(1'b1, 1'b0, q);
      host.step(1'b0, 1'b0, q);
      t_reset();
      t_bypass();
      t_config();
      t_boot();
      t_pins();
      wrap_up();
   end
endmodule : tap_boundary_scan_test
`default_nettype wire
